// file: rtl/timer_output_compare_one_pulse.sv
`timescale 1ns/100ps
module timer_output_compare_one_pulse
	import ocmp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_irq_mask_in,
	input wire logic capture_one_pin_in,
	input wire logic capture_two_pin_in,
	input wire logic ext_clk_in,
	output logic compare_one_pin_out,
	output logic compare_one_pin_oe_out,
	output logic compare_two_pin_out,
	output logic compare_two_pin_oe_out,
	output logic timer_irq_out
);
	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [2:0] cap1_sync_reg, cap2_sync_reg, ext_sync_reg;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap1_sync_reg <= 3'h0;
			cap2_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
		end
		else
		begin
			cap1_sync_reg <= {cap1_sync_reg[1:0], capture_one_pin_in};
			cap2_sync_reg <= {cap2_sync_reg[1:0], capture_two_pin_in};
			ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_in};
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg, w_data_reg, rdata_reg;
	logic w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic do_wr, rd_fire, wr_hit, rd_hit;
	logic [7:0] rd_val;
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready = !w_full_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h0, rdata_reg};
	assign wr_hit = aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= 8'h2c;
	assign rd_hit = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= 8'h2c;
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg <= 8'h0;
			w_strb_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 8'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_strb_reg <= s_axi_wstrb[0];
			end
			if (do_wr)
			begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (rd_fire)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_val;
				rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end
	logic wr_en;
	assign wr_en = do_wr && w_strb_reg;

	// ****************************************
	// control registers and mode decode
	// ****************************************
	logic [7:0] ctrl1_reg, ctrl2_reg;
	logic pwm_act, opm_act, normal1;
	logic [1:0] force_pulse, force_level, level, out_en;
	assign pwm_act = ctrl2_reg[B_PWM];
	assign opm_act = ctrl2_reg[B_SINGLE_PULSE] && !pwm_act;
	assign normal1 = !opm_act && !pwm_act;
	assign level = {ctrl1_reg[B_LEVEL_TWO], ctrl1_reg[B_LEVEL_ONE]};
	// a force copies the level written along with it, not the old one
	assign force_level = {w_data_reg[B_LEVEL_TWO], w_data_reg[B_LEVEL_ONE]};
	assign out_en = {ctrl2_reg[B_OUT_EN_TWO], ctrl2_reg[B_OUT_EN_ONE]};
	assign force_pulse = (wr_en && aw_addr_reg == OFF_CTRL_FIRST && normal1)
		? {w_data_reg[B_FORCE_TWO], w_data_reg[B_FORCE_ONE]}
		: 2'h0;
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl1_reg <= CTRL_RESET;
			ctrl2_reg <= CTRL_RESET;
		end
		else
		begin
			if (wr_en && aw_addr_reg == OFF_CTRL_FIRST)
				ctrl1_reg <= w_data_reg & 8'he7;
			if (wr_en && aw_addr_reg == OFF_CTRL_SECOND)
				ctrl2_reg <= w_data_reg;
		end
	end

	// ****************************************
	// prescaler and counter
	// ****************************************
	logic [2:0] div_reg;
	logic [15:0] cnt_reg;
	logic [1:0] presc;
	logic ext_edge, tick, eval_reg, tof_reg, tof_arm_reg, trig, cnt_wr;
	assign presc = ctrl2_reg[B_PRESCALE_HI:B_PRESCALE_LO];
	assign ext_edge = (ext_sync_reg[1] != ext_sync_reg[2])
		&& (ext_sync_reg[1] == ctrl2_reg[B_EXT_EDGE]);
	assign tick = (presc == PRESCALE_DIV2) ? div_reg[0]
		: (presc == PRESCALE_DIV4) ? &div_reg[1:0]
		: (presc == PRESCALE_DIV8) ? &div_reg : ext_edge;
	assign trig = opm_act && (cap1_sync_reg[1] != cap1_sync_reg[2])
		&& (cap1_sync_reg[1] == ctrl1_reg[B_CAP_ONE_EDGE]);
	assign cnt_wr = wr_en && aw_addr_reg == OFF_COUNTER;
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg <= 3'h0;
			cnt_reg <= COUNTER_RESET;
			eval_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_reg + 3'h1;
			eval_reg <= tick && !trig && !cnt_wr;
			if (trig || cnt_wr)
				cnt_reg <= COUNTER_RESET;
			else if (tick)
				cnt_reg <= cnt_reg + 16'h1;
		end
	end

	// ****************************************
	// per-channel compare and capture
	// ****************************************
	logic [15:0] cmp_reg [2];
	logic [15:0] cap_reg [2];
	logic [1:0] inh_reg, hit, ocf_reg, oc_arm_reg;
	logic [1:0] cap_inh_reg, icf_reg, ic_arm_reg, cap_ev, cap_en;
	logic flags_rd;
	assign flags_rd = rd_fire && s_axi_araddr == OFF_FLAGS;
	assign cap_en = {1'b1, normal1};
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		localparam logic [7:0] CMP_HI = OFF_CMP_HI_BASE + 8'(i) * CH_STRIDE;
		localparam logic [7:0] CAP_HI = OFF_CAP_HI_BASE + 8'(i) * CH_STRIDE;
		logic [15:0] target;
		logic set_ocf, lo_acc, cap_lo_acc, set_icf;
		logic [2:0] cs;
		assign cs = (i == 0) ? cap1_sync_reg : cap2_sync_reg;
		assign target = (presc == PRESCALE_DIV2) ? cmp_reg[i]
			: cmp_reg[i] + 16'h1;
		assign hit[i] = eval_reg && cnt_reg == target && !inh_reg[i];
		assign set_ocf = hit[i] && ((i == 0) ? normal1 : !pwm_act);
		assign lo_acc = (wr_en && aw_addr_reg == CMP_HI + LO_STEP)
			|| (rd_fire && s_axi_araddr == CMP_HI + LO_STEP);
		assign cap_lo_acc = (wr_en && aw_addr_reg == CAP_HI + LO_STEP)
			|| (rd_fire && s_axi_araddr == CAP_HI + LO_STEP);
		assign cap_ev[i] = cap_en[i] && !cap_inh_reg[i] && cs[1] != cs[2]
			&& cs[1] == ((i == 0) ? ctrl1_reg[B_CAP_ONE_EDGE]
			: ctrl2_reg[B_CAP_TWO_EDGE]);
		assign set_icf = cap_ev[i] || (i == 0 && trig);
		always_ff @(posedge clk_in or negedge rst_n)
		begin
			if (!rst_n)
			begin
				cmp_reg[i] <= COMPARE_RESET;
				cap_reg[i] <= 16'h0;
				inh_reg[i] <= 1'b0;
				ocf_reg[i] <= 1'b0;
				oc_arm_reg[i] <= 1'b0;
				cap_inh_reg[i] <= 1'b0;
				icf_reg[i] <= 1'b0;
				ic_arm_reg[i] <= 1'b0;
			end
			else
			begin
				if (wr_en && aw_addr_reg == CMP_HI)
				begin
					cmp_reg[i][15:8] <= w_data_reg;
					inh_reg[i] <= 1'b1;
				end
				if (wr_en && aw_addr_reg == CMP_HI + LO_STEP)
				begin
					cmp_reg[i][7:0] <= w_data_reg;
					inh_reg[i] <= 1'b0;
				end
				if (set_ocf)
					ocf_reg[i] <= 1'b1;
				else if (lo_acc && oc_arm_reg[i])
					ocf_reg[i] <= 1'b0;
				if (flags_rd && ocf_reg[i])
					oc_arm_reg[i] <= 1'b1;
				else if (lo_acc)
					oc_arm_reg[i] <= 1'b0;
				if (i == 0 && trig)
					cap_reg[i] <= CAPTURE_PULSE_VALUE;
				else if (cap_ev[i])
					cap_reg[i] <= cnt_reg;
				if (rd_fire && s_axi_araddr == CAP_HI)
					cap_inh_reg[i] <= 1'b1;
				else if (rd_fire && s_axi_araddr == CAP_HI + LO_STEP)
					cap_inh_reg[i] <= 1'b0;
				if (set_icf)
					icf_reg[i] <= 1'b1;
				else if (cap_lo_acc && ic_arm_reg[i])
					icf_reg[i] <= 1'b0;
				if (flags_rd && icf_reg[i])
					ic_arm_reg[i] <= 1'b1;
				else if (cap_lo_acc)
					ic_arm_reg[i] <= 1'b0;
			end
		end
	end

	// ****************************************
	// output pins, overflow and interrupt
	// ****************************************
	logic pin1_reg, pin2_reg, irq_reg, cnt_lo_acc;
	assign cnt_lo_acc = cnt_wr || (rd_fire && s_axi_araddr == OFF_COUNTER);
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin1_reg <= 1'b0;
			pin2_reg <= 1'b0;
			tof_reg <= 1'b0;
			tof_arm_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			if (trig)
				pin1_reg <= level[1];
			else if (hit[0] && opm_act)
				pin1_reg <= level[0];
			else if (hit[0] && normal1 && out_en[0])
				pin1_reg <= level[0];
			else if (force_pulse[0] && out_en[0])
				pin1_reg <= force_level[0];
			if (hit[1] && normal1 && out_en[1])
				pin2_reg <= level[1];
			else if (force_pulse[1] && out_en[1])
				pin2_reg <= force_level[1];
			if (tick && cnt_reg == COUNTER_TOP && !trig && !cnt_wr)
				tof_reg <= 1'b1;
			else if (cnt_lo_acc && tof_arm_reg)
				tof_reg <= 1'b0;
			if (flags_rd && tof_reg)
				tof_arm_reg <= 1'b1;
			else if (cnt_lo_acc)
				tof_arm_reg <= 1'b0;
			irq_reg <= !cpu_irq_mask_in && (
				(ctrl1_reg[B_CMP_IRQ_EN] && |ocf_reg)
				|| (ctrl1_reg[B_CAP_IRQ_EN] && |icf_reg)
				|| (ctrl1_reg[B_OVF_IRQ_EN] && tof_reg));
		end
	end
	assign compare_one_pin_out = pin1_reg;
	assign compare_two_pin_out = pin2_reg;
	assign compare_one_pin_oe_out = out_en[0];
	assign compare_two_pin_oe_out = out_en[1] && normal1;
	assign timer_irq_out = irq_reg;

	always_comb
	begin
		rd_val = 8'h0;
		unique case (s_axi_araddr)
			OFF_CTRL_FIRST: rd_val = ctrl1_reg;
			OFF_CTRL_SECOND: rd_val = ctrl2_reg;
			OFF_FLAGS: rd_val = {icf_reg[0], ocf_reg[0], tof_reg,
				icf_reg[1], ocf_reg[1], 3'h0};
			8'h0c: rd_val = cmp_reg[0][15:8];
			8'h10: rd_val = cmp_reg[0][7:0];
			8'h14: rd_val = cmp_reg[1][15:8];
			8'h18: rd_val = cmp_reg[1][7:0];
			OFF_COUNTER: rd_val = cnt_reg[7:0];
			8'h20: rd_val = cap_reg[0][15:8];
			8'h24: rd_val = cap_reg[0][7:0];
			8'h28: rd_val = cap_reg[1][15:8];
			8'h2c: rd_val = cap_reg[1][7:0];
			default: rd_val = 8'h0;
		endcase
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);
	property p_flag_on_match;
		hit[0] && normal1 |=> ocf_reg[0];
	endproperty
	a_flag_on_match: assert property (p_flag_on_match)
		else $error("match did not set flag one");
	property p_cmp_stable;
		!(wr_en && (aw_addr_reg == 8'h0c || aw_addr_reg == 8'h10))
			|=> $stable(cmp_reg[0]);
	endproperty
	a_cmp_stable: assert property (p_cmp_stable)
		else $error("compare one changed without a write");
	property p_pin_level;
		hit[0] && normal1 && out_en[0] |=> pin1_reg == $past(level[0]);
	endproperty
	a_pin_level: assert property (p_pin_level)
		else $error("pin one did not take level");
	property p_irq_mask;
		cpu_irq_mask_in |=> !timer_irq_out;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt raised while masked");
	property p_inhibit;
		inh_reg[0] && !ocf_reg[0] |=> !ocf_reg[0];
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("match while inhibited");
	property p_force_no_flag;
		force_pulse[0] && !hit[0] && !ocf_reg[0] |=> !ocf_reg[0];
	endproperty
	a_force_no_flag: assert property (p_force_no_flag)
		else $error("force set the flag");
	property p_trigger;
		trig |=> cnt_reg == COUNTER_RESET && cap_reg[0] == CAPTURE_PULSE_VALUE
			&& pin1_reg == $past(level[1]) && icf_reg[0];
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("trigger effects missing");
	property p_opm_no_flag;
		opm_act && !ocf_reg[0] ##1 opm_act |-> !ocf_reg[0];
	endproperty
	a_opm_no_flag: assert property (p_opm_no_flag)
		else $error("flag one set in single-pulse mode");
endmodule

// file: rtl/ocmp_pkg.sv
package ocmp_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL_FIRST = 8'h00;
	localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_CMP_HI_BASE = 8'h0c;
	localparam logic [7:0] OFF_COUNTER = 8'h1c;
	localparam logic [7:0] OFF_CAP_HI_BASE = 8'h20;
	localparam logic [7:0] CH_STRIDE = 8'h08;
	localparam logic [7:0] LO_STEP = 8'h04;
	// reset, reload and overflow values
	localparam logic [15:0] COMPARE_RESET = 16'h8000;
	localparam logic [15:0] COUNTER_RESET = 16'hfffc;
	localparam logic [15:0] CAPTURE_PULSE_VALUE = 16'hfffd;
	localparam logic [15:0] COUNTER_TOP = 16'hffff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// timer_control_first fields
	localparam int B_CAP_IRQ_EN = 7;
	localparam int B_CMP_IRQ_EN = 6;
	localparam int B_OVF_IRQ_EN = 5;
	localparam int B_FORCE_TWO = 4;
	localparam int B_FORCE_ONE = 3;
	localparam int B_LEVEL_TWO = 2;
	localparam int B_CAP_ONE_EDGE = 1;
	localparam int B_LEVEL_ONE = 0;
	// timer_control_second fields
	localparam int B_OUT_EN_ONE = 7;
	localparam int B_OUT_EN_TWO = 6;
	localparam int B_SINGLE_PULSE = 5;
	localparam int B_PWM = 4;
	localparam int B_PRESCALE_HI = 3;
	localparam int B_PRESCALE_LO = 2;
	localparam int B_CAP_TWO_EDGE = 1;
	localparam int B_EXT_EDGE = 0;
	// timer_flags_reg fields
	localparam int B_CAP_ONE_FLAG = 7;
	localparam int B_CMP_ONE_FLAG = 6;
	localparam int B_OVF_FLAG = 5;
	localparam int B_CAP_TWO_FLAG = 4;
	localparam int B_CMP_TWO_FLAG = 3;
	// prescale and bus response codes
	localparam logic [1:0] PRESCALE_DIV2 = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
	localparam logic [1:0] PRESCALE_DIV8 = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: tb/ocmp_pins_partner.sv
`timescale 1ns/100ps
module ocmp_pins_partner
(
	input wire logic clk_in,
	input wire logic fire_in,
	input wire logic pin_one_in,
	input wire logic oe_one_in,
	input wire logic pin_two_in,
	input wire logic oe_two_in,
	output logic capture_one_pin_out,
	output logic capture_two_pin_out,
	output logic ext_clk_out,
	output logic line_one_out,
	output logic line_two_out
);
	logic [2:0] div_reg = 3'h0;

	// ***********************
	// external count clock
	// ***********************
	// an eighth of clk_in, slower than a quarter
	always_ff @(posedge clk_in)
		div_reg <= div_reg + 3'h1;
	assign ext_clk_out = div_reg[2];

	// ***********************
	// trigger and board lines
	// ***********************
	assign capture_one_pin_out = fire_in;
	assign capture_two_pin_out = 1'b0;
	// a pin not driven by the timer floats to the board pull-up
	assign line_one_out = oe_one_in ? pin_one_in : 1'b1;
	assign line_two_out = oe_two_in ? pin_two_in : 1'b1;
endmodule

// file: tb/timer_output_compare_one_pulse_tb.sv
`timescale 1ns/100ps
module timer_output_compare_one_pulse_tb;
	import ocmp_pkg::*;
	localparam logic [7:0] C1H = OFF_CMP_HI_BASE;
	localparam logic [7:0] C1L = C1H + LO_STEP;
	localparam logic [7:0] C2H = C1H + CH_STRIDE;
	localparam logic [7:0] C2L = C2H + LO_STEP;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b1;
	logic arvalid = 1'b0;
	logic rready = 1'b1;
	logic mask = 1'b0;
	logic fire = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic cap1, cap2, extclk, p1, oe1, p2, oe2, irq, l1, l2;
	int num_errors = 0;
	int compares = 0;
	int seed = 51887;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic [7:0] v;

	always #2 clk_in = ~clk_in;

	timer_output_compare_one_pulse i_dut (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cpu_irq_mask_in(mask),
		.capture_one_pin_in(cap1), .capture_two_pin_in(cap2),
		.ext_clk_in(extclk), .compare_one_pin_out(p1),
		.compare_one_pin_oe_out(oe1), .compare_two_pin_out(p2),
		.compare_two_pin_oe_out(oe2), .timer_irq_out(irq));

	ocmp_pins_partner i_partner (.clk_in(clk_in), .fire_in(fire),
		.pin_one_in(p1), .oe_one_in(oe1), .pin_two_in(p2),
		.oe_two_in(oe2), .capture_one_pin_out(cap1),
		.capture_two_pin_out(cap2), .ext_clk_out(extclk),
		.line_one_out(l1), .line_two_out(l2));

	// ***********************
	// reporting
	// ***********************
	task results;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] x);
		compares++;
		if (seen !== x)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, x);
		end
	endtask

	task bit_chk(input logic seen, input logic x);
		check({7'h0, seen}, {7'h0, x});
	endtask

	task tmo;
		num_errors++;
		$display("[ERR] %0t wait ran out", $time);
		results();
	endtask

	// ***********************
	// bus master
	// ***********************
	task wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		logic aw_ok;
		logic w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (n > 100)
				tmo();
			if (awvalid && awready)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		while (!(bvalid && bready))
		begin
			@(posedge clk_in);
			n++;
			if (n > 100)
				tmo();
		end
		check({6'h0, bresp}, {6'h0, er});
	endtask

	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		exp_q.push_back({m, x});
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (n > 100)
				tmo();
		end while (!(arvalid && arready));
		arvalid <= 1'b0;
		while (!(rvalid && rready))
		begin
			@(posedge clk_in);
			n++;
			if (n > 100)
				tmo();
		end
		check({6'h0, rresp}, {6'h0, er});
	endtask

	// read data monitor: oldest note against each answer
	always @(posedge clk_in)
		if (rvalid && rready)
		begin
			e = exp_q.pop_front();
			check(rdata[7:0] & e[15:8], e[7:0] & e[15:8]);
		end

	// 0 pin one, 1 pin two, 2 interrupt
	task wait_sig(input int s, input logic lvl);
		int n;
		logic cur;
		n = 0;
		cur = ~lvl;
		while (cur !== lvl)
		begin
			@(posedge clk_in);
			n++;
			if (n > 2000)
				tmo();
			cur = (s == 0) ? p1 : ((s == 1) ? p2 : irq);
		end
	endtask

	// ***********************
	// main sequence
	// ***********************
	initial
	begin
		repeat (12) @(posedge clk_in);
		bit_chk(p1, 1'b0);
		bit_chk(p2, 1'b0);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		for (int i = 0; i < 4; i++)
			rd(C1H + 8'(4 * i), 8'hff, i[0] ? 8'h00 : 8'h80);
		rd(OFF_CTRL_FIRST, 8'hff, CTRL_RESET);
		rd(OFF_CTRL_SECOND, 8'hff, CTRL_RESET);
		rd(8'h30, 8'hff, 8'h00, RESP_SLVERR);
		wr(8'h30, 8'h55, RESP_SLVERR);
		wr(8'h0e, 8'h55, RESP_SLVERR);
		v = 8'h10 + 8'($random(seed) & 32'h1f);
		wr(C1H, 8'h00);
		wr(C1L, v);
		wr(OFF_CTRL_FIRST, 8'h41);
		wr(OFF_CTRL_SECOND, 8'h80);
		wr(OFF_COUNTER, 8'h00);
		wait_sig(0, 1'b1);
		wait_sig(2, 1'b1);
		rd(OFF_FLAGS, 8'h48, 8'h40);
		mask <= 1'b1;
		repeat (3) @(posedge clk_in);
		bit_chk(irq, 1'b0);
		mask <= 1'b0;
		rd(C1L, 8'hff, v);
		rd(OFF_FLAGS, 8'h40, 8'h00);
		bit_chk(irq, 1'b0);
		wr(C1H, 8'h00);
		wr(OFF_COUNTER, 8'h00);
		repeat (2 * v + 30) @(posedge clk_in);
		rd(OFF_FLAGS, 8'h40, 8'h00);
		wr(C1L, v);
		wr(OFF_COUNTER, 8'h00);
		wait_sig(2, 1'b1);
		rd(OFF_FLAGS, 8'h40, 8'h40);
		rd(C1L, 8'hff, v);
		wr(OFF_CTRL_FIRST, 8'h48);
		wait_sig(0, 1'b0);
		rd(OFF_FLAGS, 8'h40, 8'h00);
		bit_chk(irq, 1'b0);
		wr(C2H, 8'h00);
		wr(C2L, v);
		wr(OFF_CTRL_FIRST, 8'h44);
		wr(OFF_COUNTER, 8'h00);
		wait_sig(2, 1'b1);
		rd(OFF_FLAGS, 8'h48, 8'h48);
		bit_chk(oe2, 1'b0);
		bit_chk(p2, 1'b0);
		bit_chk(l2, 1'b1);
		rd(C1L, 8'hff, v);
		rd(C2L, 8'hff, v);
		wr(OFF_CTRL_FIRST, 8'h01);
		wr(OFF_CTRL_SECOND, 8'h88);
		wr(OFF_COUNTER, 8'h00);
		wait_sig(0, 1'b1);
		rd(OFF_COUNTER, 8'hff, v + 8'h01);
		bit_chk(l1, 1'b1);
		rd(OFF_FLAGS, 8'h40, 8'h40);
		rd(C1L, 8'hff, v);
		wr(OFF_CTRL_FIRST, 8'h08);
		wait_sig(0, 1'b0);
		wr(OFF_CTRL_FIRST, 8'h01);
		wr(OFF_CTRL_SECOND, 8'h8d);
		wr(OFF_COUNTER, 8'h00);
		wait_sig(0, 1'b1);
		rd(OFF_COUNTER, 8'hff, v + 8'h01);
		rd(OFF_FLAGS, 8'h40, 8'h40);
		rd(C1L, 8'hff, v);
		wr(C1H, 8'h00);
		wr(C1L, 8'h40);
		wr(OFF_CTRL_FIRST, 8'h83);
		wr(OFF_CTRL_SECOND, 8'ha0);
		fire <= 1'b1;
		wait_sig(0, 1'b0);
		wait_sig(2, 1'b1);
		rd(OFF_CAP_HI_BASE, 8'hff, CAPTURE_PULSE_VALUE[15:8]);
		rd(OFF_CAP_HI_BASE + LO_STEP, 8'hff, CAPTURE_PULSE_VALUE[7:0]);
		wait_sig(0, 1'b1);
		rd(OFF_FLAGS, 8'hc0, 8'h80);
		wr(OFF_CTRL_FIRST, 8'h8a);
		repeat (4) @(posedge clk_in);
		bit_chk(p1, 1'b1);
		results();
	end
endmodule
